// ===== verilog/cwst_cfg.svh
`ifndef CWST_CFG_SVH
`define CWST_CFG_SVH
// ***************************************************
// timing base
// ***************************************************
`define CWST_CLK_MHZ 200
`define CWST_TICK_NS 100000
`define CWST_TICK_CYC ((`CWST_TICK_NS * `CWST_CLK_MHZ) / 1000)
`define CWST_FILT_US 16
`define CWST_FILT_CYC ((`CWST_FILT_US * `CWST_CLK_MHZ))
// ***************************************************
// on-time codes
// ***************************************************
`define CWST_ON_OFF_LOW 3'h0
`define CWST_ON_0P1MS 3'h1
`define CWST_ON_0P3MS 3'h2
`define CWST_ON_1MS 3'h3
`define CWST_ON_10MS 3'h4
`define CWST_ON_20MS 3'h5
`define CWST_ON_OFF_HIGH 3'h6
`define CWST_ON_OFF_HIGH2 3'h7
`define CWST_RST_PULSE_CYC 8'h10
`endif

// ===== verilog/cwst_pkg.sv
`default_nettype none
package cwst_pkg;
    typedef enum logic [1:0] {
        CWST_NORMAL = 2'h0,
        CWST_STOP = 2'h1,
        CWST_SLEEP = 2'h3,
        CWST_RESTART = 2'h2
    } cwst_mode_type;
endpackage : cwst_pkg
`default_nettype wire

// ===== verilog/cwst_tick_div.sv
`timescale 1ns/1ps
`default_nettype none
`include "cwst_cfg.svh"
// ***************************************************
// 0.1 ms tick divider
// ***************************************************
module cwst_tick_div #(
    parameter int DIV = 20000
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_clear,
    output logic o_tick
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    always_comb begin
        cnt_nxt = cnt_r + 32'h1;
        if (i_clear || cnt_r == 32'(DIV - 1)) begin
            cnt_nxt = 32'h0;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            cnt_r <= 32'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
    assign o_tick = !i_clear && (cnt_r == 32'(DIV - 1));
endmodule : cwst_tick_div
`default_nettype wire

// ===== verilog/cwst_timer.sv
// What this block does
// RL1: host enables cyclic sensing in normal mode before entering stop or sleep.
// RL2: a cyclic-sense wake sets the wake pin event flag.
// RL3: sense wake interrupts in stop mode, restarts to normal from sleep.
// RL4: sleep request with wake flags set wakes at once and pulses reset.
// RL5: high-side overcurrent in sleep with sense only source leaves sleep.
// RL6: cyclic wake interrupts each period in normal/stop, restarts from sleep.
// RL7: host enables timer wake source, then sets period and valid on-time.
// RL8: timer starts as soon as a valid on-time is written.
// RL9: wake interrupt at each on-time start except the first after start.
// RL10: sixteen periods from 10 ms to 1000 s.
// RL11: on-times 0.1, 0.3, 1, 10, 20 ms, or off high or low.
// RL12: sense and wake share one timer and its settings.
// RL13: high-side pin follows on-time when mapped to the timer.
// RL14: first sample is reference; wake on change from previous sample.
// RL15: 16 us filter after on-time; change valid only if stable.
// RL16: command fault when on-time exceeds period.
// RL17: counts from oscillator, on-time at period start, cleared in restart.
// RL18: off code stops timer, holds output static, no interrupts.
`timescale 1ns/1ps
`default_nettype none
`include "cwst_cfg.svh"
module cwst_timer #(
    parameter int TICK_DIV = `CWST_TICK_CYC,
    parameter int FILT_CYC = `CWST_FILT_CYC
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // configuration
    input wire logic [3:0] i_period_sel,
    input wire logic [2:0] i_on_time_sel,
    input wire logic i_on_time_wr,
    input wire logic i_timer_wake_en,
    input wire logic i_sense_map_hs,
    input wire logic i_sense_wake_en,
    input wire logic i_other_wake_src,
    // mode and status
    input wire cwst_pkg::cwst_mode_type i_mode,
    input wire logic i_sleep_req,
    input wire logic i_wake_status_first_set,
    input wire logic i_wake_status_second_set,
    input wire logic i_wake_clear,
    input wire logic i_hs_overcurrent,
    input wire logic i_high_voltage_sense_input,
    // outputs
    output logic o_high_side_switch,
    output logic o_interrupt_out_n,
    output logic o_reset_out_n,
    output logic o_wake_pin_event_flag,
    output logic o_timer_wake_flag,
    output logic o_cmd_fault,
    output logic o_enter_sleep,
    output logic o_restart_req
);
    // ***************************************************
    // period and on-time lookup, in 0.1 ms ticks
    // ***************************************************
    function automatic logic [23:0] period_ticks(input logic [3:0] s);
        unique case (s) // RL10
            4'h0: period_ticks = 24'd100;
            4'h1: period_ticks = 24'd200;
            4'h2: period_ticks = 24'd500;
            4'h3: period_ticks = 24'd1000;
            4'h4: period_ticks = 24'd2000;
            4'h5: period_ticks = 24'd5000;
            4'h6: period_ticks = 24'd10000;
            4'h7: period_ticks = 24'd20000;
            4'h8: period_ticks = 24'd50000;
            4'h9: period_ticks = 24'd100000;
            4'ha: period_ticks = 24'd200000;
            4'hb: period_ticks = 24'd500000;
            4'hc: period_ticks = 24'd1000000;
            4'hd: period_ticks = 24'd2000000;
            4'he: period_ticks = 24'd5000000;
            4'hf: period_ticks = 24'd10000000;
        endcase
    endfunction : period_ticks
    function automatic logic [23:0] on_ticks(input logic [2:0] s);
        unique case (s) // RL11
            `CWST_ON_0P1MS: on_ticks = 24'd1;
            `CWST_ON_0P3MS: on_ticks = 24'd3;
            `CWST_ON_1MS: on_ticks = 24'd10;
            `CWST_ON_10MS: on_ticks = 24'd100;
            `CWST_ON_20MS: on_ticks = 24'd200;
            default: on_ticks = 24'd0;
        endcase
    endfunction : on_ticks
    function automatic logic on_valid(input logic [2:0] s);
        on_valid = (s != `CWST_ON_OFF_LOW) && (s != `CWST_ON_OFF_HIGH)
            && (s != `CWST_ON_OFF_HIGH2);
    endfunction : on_valid
    // ***************************************************
    // synchronisers and tick
    // ***************************************************
    logic wk_s1_r, wk_s2_r, oc_s1_r, oc_s2_r;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            wk_s1_r <= 1'b0;
            wk_s2_r <= 1'b0;
            oc_s1_r <= 1'b0;
            oc_s2_r <= 1'b0;
        end else begin
            wk_s1_r <= i_high_voltage_sense_input;
            wk_s2_r <= wk_s1_r;
            oc_s1_r <= i_hs_overcurrent;
            oc_s2_r <= oc_s1_r;
        end
    end
    logic in_restart, tick;
    assign in_restart = (i_mode == cwst_pkg::CWST_RESTART);
    cwst_tick_div #(.DIV(TICK_DIV)) u_div (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_clear(in_restart || i_on_time_wr),
        .o_tick(tick)
    );
    // ***************************************************
    // shared timer
    // ***************************************************
    logic run_r, run_nxt, first_r, first_nxt, on_r, on_nxt;
    logic [23:0] cnt_r, cnt_nxt;
    logic [2:0] on_sel_r, on_sel_nxt;
    logic start_pulse;
    always_comb begin
        run_nxt = run_r;
        first_nxt = first_r;
        cnt_nxt = cnt_r;
        on_sel_nxt = on_sel_r;
        start_pulse = 1'b0;
        if (in_restart) begin
            run_nxt = 1'b0; // RL17
            cnt_nxt = 24'h0;
            on_sel_nxt = `CWST_ON_OFF_LOW;
        end else if (i_on_time_wr) begin
            on_sel_nxt = i_on_time_sel;
            run_nxt = on_valid(i_on_time_sel); // RL8 RL18
            first_nxt = 1'b1;
            cnt_nxt = 24'h0;
            start_pulse = on_valid(i_on_time_sel);
        end else if (run_r && tick) begin
            if (cnt_r >= period_ticks(i_period_sel) - 24'h1) begin
                cnt_nxt = 24'h0; // RL17
                start_pulse = 1'b1;
                first_nxt = 1'b0;
            end else begin
                cnt_nxt = cnt_r + 24'h1;
            end
        end
    end
    always_comb begin
        on_nxt = run_nxt && (cnt_nxt < on_ticks(on_sel_nxt)); // RL12
    end
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            run_r <= 1'b0;
            first_r <= 1'b1;
            cnt_r <= 24'h0;
            on_sel_r <= `CWST_ON_OFF_LOW;
            on_r <= 1'b0;
        end else begin
            run_r <= run_nxt;
            first_r <= first_nxt;
            cnt_r <= cnt_nxt;
            on_sel_r <= on_sel_nxt;
            on_r <= on_nxt;
        end
    end
    // ***************************************************
    // sense sampling and filter
    // ***************************************************
    logic ref_r, ref_nxt, have_ref_r, have_ref_nxt, filt_r, filt_nxt, smp_r, smp_nxt;
    logic [15:0] fcnt_r, fcnt_nxt;
    logic sense_evt, on_fall;
    assign on_fall = on_r && !on_nxt;
    always_comb begin
        ref_nxt = ref_r;
        have_ref_nxt = have_ref_r;
        filt_nxt = filt_r;
        smp_nxt = smp_r;
        fcnt_nxt = fcnt_r;
        sense_evt = 1'b0;
        if (in_restart || i_on_time_wr) begin
            have_ref_nxt = 1'b0; // RL14
            filt_nxt = 1'b0;
        end else if (on_fall && i_sense_map_hs) begin
            filt_nxt = 1'b1; // RL15
            smp_nxt = wk_s2_r;
            fcnt_nxt = 16'h0;
        end else if (filt_r) begin
            if (wk_s2_r != smp_r) begin
                filt_nxt = 1'b0; // RL15
            end else if (fcnt_r == 16'(FILT_CYC - 1)) begin
                filt_nxt = 1'b0;
                have_ref_nxt = 1'b1;
                ref_nxt = smp_r;
                sense_evt = have_ref_r && (smp_r != ref_r) && i_sense_wake_en; // RL14
            end else begin
                fcnt_nxt = fcnt_r + 16'h1;
            end
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            ref_r <= 1'b0;
            have_ref_r <= 1'b0;
            filt_r <= 1'b0;
            smp_r <= 1'b0;
            fcnt_r <= 16'h0;
        end else begin
            ref_r <= ref_nxt;
            have_ref_r <= have_ref_nxt;
            filt_r <= filt_nxt;
            smp_r <= smp_nxt;
            fcnt_r <= fcnt_nxt;
        end
    end
    // ***************************************************
    // wake, interrupt, sleep and reset handling
    // ***************************************************
    logic wake_evt, timer_evt, sleep, flags_set, oc_exit;
    logic pin_flag_r, pin_flag_nxt, tmr_flag_r, tmr_flag_nxt, int_r, int_nxt;
    logic rst_r, rst_nxt, restart_r, restart_nxt, fault_r, fault_nxt;
    logic [7:0] rcnt_r, rcnt_nxt;
    assign sleep = (i_mode == cwst_pkg::CWST_SLEEP);
    // the start pulse at the write itself is the one left silent
    assign timer_evt = start_pulse && !first_nxt && i_timer_wake_en; // RL9 RL6
    assign oc_exit = sleep && oc_s2_r && i_sense_map_hs && !i_other_wake_src // RL5
        && !i_timer_wake_en;
    assign flags_set = i_wake_status_first_set || i_wake_status_second_set
        || pin_flag_r || tmr_flag_r;
    assign wake_evt = sense_evt || timer_evt;
    always_comb begin
        pin_flag_nxt = (pin_flag_r && !i_wake_clear) || sense_evt; // RL2
        tmr_flag_nxt = (tmr_flag_r && !i_wake_clear) || timer_evt;
        int_nxt = wake_evt && !sleep && !in_restart; // RL3 RL6
        restart_nxt = (wake_evt && sleep) || oc_exit // RL3 RL5 RL6
            || (i_sleep_req && flags_set); // RL4
        fault_nxt = on_valid(on_sel_r) // RL16
            && (on_ticks(on_sel_r) > period_ticks(i_period_sel));
        rcnt_nxt = rcnt_r;
        rst_nxt = 1'b1;
        if (i_sleep_req && flags_set) begin
            rcnt_nxt = `CWST_RST_PULSE_CYC; // RL4
        end else if (rcnt_r != 8'h0) begin
            rcnt_nxt = rcnt_r - 8'h1;
        end
        if (rcnt_nxt != 8'h0) begin
            rst_nxt = 1'b0;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            pin_flag_r <= 1'b0;
            tmr_flag_r <= 1'b0;
            int_r <= 1'b0;
            restart_r <= 1'b0;
            fault_r <= 1'b0;
            rcnt_r <= 8'h0;
            rst_r <= 1'b1;
        end else begin
            pin_flag_r <= pin_flag_nxt;
            tmr_flag_r <= tmr_flag_nxt;
            int_r <= int_nxt;
            restart_r <= restart_nxt;
            fault_r <= fault_nxt;
            rcnt_r <= rcnt_nxt;
            rst_r <= rst_nxt;
        end
    end
    // ***************************************************
    // outputs
    // ***************************************************
    logic hs_r;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            hs_r <= 1'b0;
        end else if (!i_sense_map_hs || oc_s2_r) begin
            hs_r <= 1'b0;
        end else if (run_r) begin
            hs_r <= on_r; // RL13
        end else begin
            hs_r <= on_sel_r[2] && on_sel_r[1]; // RL18
        end
    end
    assign o_high_side_switch = hs_r;
    assign o_interrupt_out_n = !int_r;
    assign o_reset_out_n = rst_r;
    assign o_wake_pin_event_flag = pin_flag_r;
    assign o_timer_wake_flag = tmr_flag_r;
    assign o_cmd_fault = fault_r;
    assign o_restart_req = restart_r;
    assign o_enter_sleep = i_sleep_req && !flags_set;
endmodule : cwst_timer
`default_nettype wire

// ===== sim/cwst_timer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// timer port checker
// ****************
module cwst_timer_assertions #(
    parameter int TICK_DIV = 2,
    parameter int FILT_CYC = 4
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // inputs
    input wire logic [2:0] i_on_time_sel,
    input wire logic i_on_time_wr,
    input wire logic i_sense_map_hs,
    input wire cwst_pkg::cwst_mode_type i_mode,
    input wire logic i_sleep_req,
    input wire logic i_wake_status_first_set,
    input wire logic i_wake_status_second_set,
    input wire logic i_wake_clear,
    input wire logic i_hs_overcurrent,
    // outputs
    input wire logic o_high_side_switch,
    input wire logic o_interrupt_out_n,
    input wire logic o_reset_out_n,
    input wire logic o_timer_wake_flag,
    input wire logic o_enter_sleep,
    input wire logic o_restart_req
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    wire logic flags_set = i_wake_status_first_set | i_wake_status_second_set;
    a_int_one_cycle: assert property ($fell(o_interrupt_out_n) |=> o_interrupt_out_n)
        else $error("interrupt low longer than one cycle");
    a_reset_pulse_len: assert property ($fell(o_reset_out_n) |->
        (!o_reset_out_n)[*8] ##1 (!o_reset_out_n)[*8] ##1 o_reset_out_n)
        else $error("reset pulse not 16 cycles");
    a_sleep_refused: assert property ((i_sleep_req && flags_set) |-> !o_enter_sleep)
        else $error("sleep accepted with flags set");
    a_sleep_flag_restart: assert property ((i_sleep_req && flags_set) |=> o_restart_req)
        else $error("no restart after refused sleep");
    a_hs_on_start: assert property ((i_on_time_wr && i_on_time_sel inside {[3'h1:3'h5]}
        && i_sense_map_hs && !i_hs_overcurrent && i_mode != cwst_pkg::CWST_RESTART)
        |-> ##2 o_high_side_switch)
        else $error("high side not on two cycles after write");
    a_oc_hs_off: assert property (i_hs_overcurrent[*3] |=> !o_high_side_switch)
        else $error("high side on during overcurrent");
    a_sleep_no_int: assert property ((i_mode == cwst_pkg::CWST_SLEEP
        && $past(i_mode) == cwst_pkg::CWST_SLEEP && $past(i_mode, 2) == cwst_pkg::CWST_SLEEP)
        |-> o_interrupt_out_n)
        else $error("interrupt in sleep mode");
    a_flag_sticky: assert property ($fell(o_timer_wake_flag) |-> $past(i_wake_clear))
        else $error("timer flag cleared without clear");
endmodule : cwst_timer_assertions
bind cwst_timer cwst_timer_assertions #(.TICK_DIV(TICK_DIV), .FILT_CYC(FILT_CYC))
    cwst_timer_assertions_inst (.i_sys_clk, .i_rst_b, .i_on_time_sel, .i_on_time_wr,
    .i_sense_map_hs, .i_mode, .i_sleep_req, .i_wake_status_first_set,
    .i_wake_status_second_set, .i_wake_clear, .i_hs_overcurrent, .o_high_side_switch,
    .o_interrupt_out_n, .o_reset_out_n, .o_timer_wake_flag, .o_enter_sleep, .o_restart_req);
`default_nettype wire

// ===== sim/cwst_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// host configuration model
// ****************
module cwst_host_model (
    // clock
    input wire logic i_sys_clk,
    // configuration
    output logic o_timer_wake_en,
    output logic o_sense_map_hs,
    output logic [3:0] o_period_sel,
    output logic [2:0] o_on_time_sel,
    output logic o_on_time_wr
);
    initial begin
        o_timer_wake_en = 1'b0;
        o_sense_map_hs = 1'b0;
        o_period_sel = 4'h0;
        o_on_time_sel = 3'h0;
        o_on_time_wr = 1'b0;
    end
    // sources and period first, on-time write last; caller keeps normal mode
    task automatic cfg(input logic te, input logic se, input logic [3:0] per,
        input logic [2:0] on);
        @(posedge i_sys_clk);
        o_timer_wake_en <= te;
        o_sense_map_hs <= se;
        o_period_sel <= per;
        @(posedge i_sys_clk);
        o_on_time_sel <= on;
        o_on_time_wr <= 1'b1;
        @(posedge i_sys_clk);
        o_on_time_wr <= 1'b0;
    endtask : cfg
endmodule : cwst_host_model
`default_nettype wire

// ===== sim/cwst_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// timer testbench
// ****************
module cwst_timer_tb;
    logic i_sys_clk, i_rst_b, i_on_time_wr, i_timer_wake_en, i_sense_map_hs;
    logic i_sleep_req, i_wake_status_first_set, i_wake_status_second_set, i_wake_clear;
    logic i_hs_overcurrent, i_high_voltage_sense_input, i_other_wake_src;
    logic [3:0] i_period_sel;
    logic [2:0] i_on_time_sel;
    cwst_pkg::cwst_mode_type i_mode;
    logic o_high_side_switch, o_interrupt_out_n, o_reset_out_n, o_wake_pin_event_flag;
    logic o_timer_wake_flag, o_cmd_fault, o_enter_sleep, o_restart_req, ent;
    int failures = 0, compares = 0, ints, rsts, rlow, hsw;
    logic [31:0] lfsr = 32'h938fc24b;
    cwst_timer #(.TICK_DIV(2), .FILT_CYC(4)) cwst_timer_inst (.i_sys_clk, .i_rst_b,
        .i_period_sel, .i_on_time_sel, .i_on_time_wr, .i_timer_wake_en, .i_sense_map_hs,
        .i_sense_wake_en(i_sense_map_hs), .i_other_wake_src, .i_mode, .i_sleep_req,
        .i_wake_status_first_set, .i_wake_status_second_set, .i_wake_clear,
        .i_hs_overcurrent, .i_high_voltage_sense_input, .o_high_side_switch,
        .o_interrupt_out_n, .o_reset_out_n, .o_wake_pin_event_flag, .o_timer_wake_flag,
        .o_cmd_fault, .o_enter_sleep, .o_restart_req);
    cwst_host_model cwst_host_model_inst (.i_sys_clk, .o_timer_wake_en(i_timer_wake_en),
        .o_sense_map_hs(i_sense_map_hs), .o_period_sel(i_period_sel),
        .o_on_time_sel(i_on_time_sel), .o_on_time_wr(i_on_time_wr));
    initial begin
        i_sys_clk = 1'b0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        if (o_interrupt_out_n === 1'b0) ints++;
        if (o_restart_req === 1'b1) rsts++;
        if (o_reset_out_n === 1'b0) rlow++;
        if (o_high_side_switch === 1'b1) hsw++;
    end
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt
    // only 20 ms on-time against a 10 ms period is longer
    function automatic logic exp_fault(input logic [3:0] per, input logic [2:0] on);
        return (on == 3'h5) && (per == 4'h0);
    endfunction : exp_fault
    task automatic chk_bit(input string n, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %b seen %b", n, e, g);
        end
    endtask : chk_bit
    task automatic chk_cnt(input string n, input int e, input int g);
        compares++;
        if (g != e) begin
            failures++;
            $display("MISMATCH %s expected %0d seen %0d", n, e, g);
        end
    endtask : chk_cnt
    task automatic wt(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask : wt
    task automatic rst();
        @(posedge i_sys_clk);
        i_rst_b <= 1'b0;
        i_mode <= cwst_pkg::CWST_NORMAL;
        i_hs_overcurrent <= 1'b0;
        i_high_voltage_sense_input <= 1'b0;
        wt(4);
        i_rst_b <= 1'b1;
        @(negedge i_sys_clk);
        {ints, rsts, rlow, hsw} = '0;
    endtask : rst
    task automatic slp();
        @(posedge i_sys_clk);
        i_sleep_req <= 1'b1;
        @(negedge i_sys_clk);
        ent = o_enter_sleep;
        @(posedge i_sys_clk);
        i_sleep_req <= 1'b0;
    endtask : slp
    task automatic summarize();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (60000) @(posedge i_sys_clk);
        failures++;
        summarize();
    end
    initial begin
        {i_rst_b, i_sleep_req, i_wake_status_first_set, i_wake_status_second_set} = '0;
        {i_wake_clear, i_hs_overcurrent, i_high_voltage_sense_input, i_other_wake_src} = '0;
        i_mode = cwst_pkg::CWST_NORMAL;
        rst();
        chk_bit("int_n", 1'b1, o_interrupt_out_n);
        chk_bit("reset_out_n", 1'b1, o_reset_out_n);
        chk_bit("hs", 1'b0, o_high_side_switch);
        cwst_host_model_inst.cfg(1'b1, 1'b1, 4'h0, 3'h1);
        wt(450);
        chk_cnt("wake ints", 2, ints);
        chk_cnt("hs on cycles", 3 * 2, hsw);
        chk_bit("timer flag", 1'b1, o_timer_wake_flag);
        i_wake_clear <= 1'b1;
        wt(1);
        i_wake_clear <= 1'b0;
        wt(2);
        chk_bit("timer flag", 1'b0, o_timer_wake_flag);
        $display("normal cyclic wake done");
        rst();
        cwst_host_model_inst.cfg(1'b1, 1'b0, 4'h0, 3'h3);
        i_mode <= cwst_pkg::CWST_SLEEP;
        wt(450);
        chk_cnt("sleep ints", 0, ints);
        chk_cnt("sleep restarts", 2, rsts);
        $display("sleep cyclic wake done");
        rst();
        for (int k = 0; k < 8; k++) begin
            lfsr = nxt(lfsr);
            cwst_host_model_inst.cfg(1'b0, 1'b1, k[0] ? lfsr[3:0] : 4'h0,
                (k == 0) ? 3'h5 : lfsr[6:4]);
            wt(3);
            chk_bit("cmd fault", exp_fault(i_period_sel, i_on_time_sel), o_cmd_fault);
            if (i_on_time_sel inside {3'h0, 3'h6, 3'h7}) begin
                chk_bit("hs static", i_on_time_sel != 3'h0, o_high_side_switch);
            end
        end
        cwst_host_model_inst.cfg(1'b1, 1'b1, 4'h0, 3'h6);
        ints = 0;
        wt(450);
        chk_cnt("off ints", 0, ints);
        chk_bit("hs off high", 1'b1, o_high_side_switch);
        $display("codes and fault done");
        for (int f = 0; f < 3; f++) begin
            rst();
            i_wake_status_first_set <= (f == 0);
            i_wake_status_second_set <= (f == 1);
            slp();
            wt(30);
            chk_bit("enter sleep", f == 2, ent);
            chk_cnt("reset low", (f < 2) ? 16 : 0, rlow);
            chk_cnt("restarts", (f < 2) ? 1 : 0, rsts);
        end
        $display("sleep entry done");
        rst();
        cwst_host_model_inst.cfg(1'b0, 1'b1, 4'h0, 3'h1);
        i_mode <= cwst_pkg::CWST_STOP;
        wt(50);
        i_high_voltage_sense_input <= 1'b1;
        wt(250);
        chk_cnt("sense ints", 1, ints);
        chk_bit("pin flag", 1'b1, o_wake_pin_event_flag);
        $display("cyclic sense done");
        rst();
        cwst_host_model_inst.cfg(1'b0, 1'b1, 4'h0, 3'h4);
        i_mode <= cwst_pkg::CWST_SLEEP;
        wt(20);
        i_hs_overcurrent <= 1'b1;
        wt(10);
        chk_bit("oc exit", 1'b1, o_restart_req);
        chk_bit("oc hs", 1'b0, o_high_side_switch);
        i_other_wake_src <= 1'b1;
        wt(3);
        chk_bit("oc other src", 1'b0, o_restart_req);
        $display("overcurrent exit done");
        summarize();
    end
endmodule : cwst_timer_tb
`default_nettype wire
